// ==== rim_consts.vh ====
`ifndef RIM_CONSTS_VH
`define RIM_CONSTS_VH
// ==========================================================
// register offsets
`define RIM_OFS_DES_ADDR 8'h06
`define RIM_OFS_PHYS_ADDR 8'h07
`define RIM_OFS_ALIAS_ADDR 8'h08
`define RIM_OFS_ERRCNT_LO 8'h0a
`define RIM_OFS_ERRCNT_HI 8'h0b
`define RIM_OFS_STATUS 8'h0c
// ==========================================================
// field layout
`define RIM_ADDR_MSB 7
`define RIM_ADDR_LSB 1
`define RIM_ST_SELFTEST_ERR 3
`define RIM_ST_PCLK_VALID 2
`define RIM_ST_DES_ERR 1
`define RIM_ST_LINK 0
// ==========================================================
// reset values and counter limit
`define RIM_RST_ADDR 7'h00
`define RIM_RST_BYTE 8'h00
`define RIM_RST_COUNT 16'h0000
`define RIM_COUNT_MAX 16'hffff
`endif

// ==== rim_far_end.sv ====
`timescale 1ns/1ps
// ==========================================================
// far end: control-channel events as one-cycle pulses
module rim_far_end (
	input wire clk,
	output reg [6:0] learnedAddr,
	output reg [4:0] ev
);
	initial begin
		learnedAddr = 7'h00;
		ev = 5'h00;
	end
	// ev: learned, backchannel error, restart, selftest error, des error
	task send(input [4:0] k, input [6:0] a, input int gap);
		repeat (gap) @(posedge clk);
		@(posedge clk) #1;
		ev = k;
		learnedAddr = a;
		@(posedge clk) #1;
		ev = 5'h00;
		// released bus must not look like a stale valid address
		learnedAddr = ~a;
	endtask
endmodule

// ==== rim_link_status.v ====
// Functional notes
// RQ1 - remote deserializer address; zero blocks forwarding
// RQ2 - after lock, learned address loads unless frozen
// RQ3 - software writing address should also freeze; a write does not freeze, only the addressFreeze input does
// RQ4 - alias hits are remapped to physical address
// RQ5 - alias compare; zero alias disables remote access
// RQ6 - 16-bit error counter, bytes at 0x0a/0x0b
// RQ7 - counter-clear control zeroes both counter bytes
// RQ8 - clear not self-clearing; held clear holds zero
// RQ9 - self-test error bit: link loss/restart/clear
// RQ10 - status bit 2 follows valid pixel clock
// RQ11 - deserializer error bit: cleared link loss/clear
// RQ12 - status bit 0 follows cable link detect
// RQ13 - reserved bits read zero; counter saturates
`timescale 1ns/1ps
`include "rim_consts.vh"
module rim_link_status (
	clk,
	rst,
	regAddr,
	regWrite,
	regRead,
	regWdata,
	regRdata,
	counterClear,
	addressFreeze,
	rxLockPin,
	linkDetectPin,
	pclkValidPin,
	learnedAddr,
	learnedValid,
	backchannelCrcErr,
	selftestRestart,
	selftestCrcErr,
	desCrcErr,
	i2cAddr,
	i2cAddrValid,
	fwdValid,
	fwdAddr,
	fwdToTarget,
	remoteDesAddr
);
	input wire clk;
	input wire rst;
	input wire [7:0] regAddr;
	input wire regWrite;
	input wire regRead;
	input wire [7:0] regWdata;
	output reg [7:0] regRdata;
	input wire counterClear;
	input wire addressFreeze;
	input wire rxLockPin;
	input wire linkDetectPin;
	input wire pclkValidPin;
	input wire [6:0] learnedAddr;
	input wire learnedValid;
	input wire backchannelCrcErr;
	input wire selftestRestart;
	input wire selftestCrcErr;
	input wire desCrcErr;
	input wire [6:0] i2cAddr;
	input wire i2cAddrValid;
	output reg fwdValid;
	output reg [6:0] fwdAddr;
	output reg fwdToTarget;
	output reg [6:0] remoteDesAddr;

	// ==========================================================
	// pin synchronisation
	wire [2:0] pinSync;
	wire rxLock;
	wire linkUp;
	wire pclkValid;

	rim_sync3 #(
		.WIDTH(3)
	) uSync (
		.clk(clk),
		.rst(rst),
		.asyncIn({rxLockPin, linkDetectPin, pclkValidPin}),
		.syncOut(pinSync)
	);

	assign rxLock = pinSync[2];
	assign linkUp = pinSync[1];
	assign pclkValid = pinSync[0];

	reg linkPrev_reg;
	wire linkLost;

	always @(posedge clk) begin
		if (rst) begin
			linkPrev_reg <= 1'b0;
		end else begin
			linkPrev_reg <= linkUp;
		end
	end

	assign linkLost = linkPrev_reg & ~linkUp;

	// ==========================================================
	// address registers
	reg [6:0] physAddr_reg;
	reg [6:0] aliasAddr_reg;
	wire wrDes;
	wire wrPhys;
	wire wrAlias;

	assign wrDes = regWrite && (regAddr == `RIM_OFS_DES_ADDR);
	assign wrPhys = regWrite && (regAddr == `RIM_OFS_PHYS_ADDR);
	assign wrAlias = regWrite && (regAddr == `RIM_OFS_ALIAS_ADDR);

	always @(posedge clk) begin
		if (rst) begin
			remoteDesAddr <= `RIM_RST_ADDR; // RQ1
			physAddr_reg <= `RIM_RST_ADDR;
			aliasAddr_reg <= `RIM_RST_ADDR;
		end else begin
			// software write takes priority over a learned value in the same cycle
			if (wrDes) begin
				remoteDesAddr <= regWdata[`RIM_ADDR_MSB:`RIM_ADDR_LSB]; // RQ3
			end else if (learnedValid && rxLock && !addressFreeze) begin
				remoteDesAddr <= learnedAddr; // RQ2
			end
			if (wrPhys) begin
				physAddr_reg <= regWdata[`RIM_ADDR_MSB:`RIM_ADDR_LSB]; // RQ4
			end
			if (wrAlias) begin
				aliasAddr_reg <= regWdata[`RIM_ADDR_MSB:`RIM_ADDR_LSB]; // RQ5
			end
		end
	end

	// ==========================================================
	// address decode and remap
	wire aliasHit;
	wire desHit;

	assign aliasHit = (aliasAddr_reg != `RIM_RST_ADDR) && (i2cAddr == aliasAddr_reg); // RQ5
	assign desHit = (remoteDesAddr != `RIM_RST_ADDR) && (i2cAddr == remoteDesAddr); // RQ1

	always @(posedge clk) begin
		if (rst) begin
			fwdValid <= 1'b0;
			fwdAddr <= `RIM_RST_ADDR;
			fwdToTarget <= 1'b0;
		end else begin
			fwdValid <= i2cAddrValid && (aliasHit || desHit);
			if (i2cAddrValid && aliasHit) begin
				fwdAddr <= physAddr_reg; // RQ4
				fwdToTarget <= 1'b1;
			end else if (i2cAddrValid && desHit) begin
				fwdAddr <= remoteDesAddr; // RQ1
				fwdToTarget <= 1'b0;
			end
		end
	end

	// ==========================================================
	// back-channel error counter
	reg [15:0] errCount_reg;

	always @(posedge clk) begin
		if (rst) begin
			errCount_reg <= `RIM_RST_COUNT; // RQ6
		end else if (counterClear) begin
			// level-held clear keeps the count at zero until software drops it
			errCount_reg <= `RIM_RST_COUNT; // RQ7 RQ8
		end else if (backchannelCrcErr && (errCount_reg != `RIM_COUNT_MAX)) begin
			errCount_reg <= errCount_reg + 16'h0001; // RQ13
		end
	end

	// ==========================================================
	// status flags
	reg selftestErr_reg;
	reg desErr_reg;
	reg linkStat_reg;
	reg pclkStat_reg;

	always @(posedge clk) begin
		if (rst) begin
			selftestErr_reg <= 1'b0;
			desErr_reg <= 1'b0;
			linkStat_reg <= 1'b0;
			pclkStat_reg <= 1'b0;
		end else begin
			linkStat_reg <= linkUp; // RQ12
			pclkStat_reg <= pclkValid; // RQ10
			// an error arriving with a clear is kept, so no event is lost
			if (selftestCrcErr) begin
				selftestErr_reg <= 1'b1; // RQ9
			end else if (linkLost || selftestRestart || counterClear) begin
				selftestErr_reg <= 1'b0; // RQ9
			end
			if (desCrcErr) begin
				desErr_reg <= 1'b1; // RQ11
			end else if (linkLost || counterClear) begin
				desErr_reg <= 1'b0; // RQ11
			end
		end
	end

	// ==========================================================
	// register read port
	reg [7:0] readMux;

	always @* begin
		readMux = `RIM_RST_BYTE; // RQ13
		case (regAddr)
			`RIM_OFS_DES_ADDR: begin
				readMux = {remoteDesAddr, 1'b0};
			end
			`RIM_OFS_PHYS_ADDR: begin
				readMux = {physAddr_reg, 1'b0};
			end
			`RIM_OFS_ALIAS_ADDR: begin
				readMux = {aliasAddr_reg, 1'b0};
			end
			`RIM_OFS_ERRCNT_LO: begin
				readMux = errCount_reg[7:0]; // RQ6
			end
			`RIM_OFS_ERRCNT_HI: begin
				readMux = errCount_reg[15:8]; // RQ6
			end
			`RIM_OFS_STATUS: begin
				readMux = {4'h0, selftestErr_reg, pclkStat_reg, desErr_reg, linkStat_reg};
			end
			default: begin
				readMux = `RIM_RST_BYTE;
			end
		endcase
	end

	// limitation: the two count bytes are read separately, so a carry between reads can tear
	always @(posedge clk) begin
		if (rst) begin
			regRdata <= `RIM_RST_BYTE;
		end else if (regRead) begin
			regRdata <= readMux;
		end
	end
endmodule

// ==== rim_link_status_chk.sv ====
`timescale 1ns/1ps
module rim_link_status_chk (
	input logic clk,
	input logic rst,
	input logic [7:0] regAddr,
	input logic regWrite,
	input logic regRead,
	input logic [7:0] regWdata,
	input logic [7:0] regRdata,
	input logic counterClear,
	input logic addressFreeze,
	input logic learnedValid,
	input logic [6:0] i2cAddr,
	input logic i2cAddrValid,
	input logic fwdValid,
	input logic [6:0] remoteDesAddr
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence rdAt(a);
		regRead && regAddr == a;
	endsequence
	// one edge of clear must land before the read edge
	sequence clrHeld;
		counterClear ##1 counterClear && regRead && regAddr[7:1] == 7'h05;
	endsequence
	chk_des_write: assert property (regWrite && regAddr == 8'h06 |=> remoteDesAddr == $past(regWdata[7:1]))
		else $error("des write lost");
	chk_des_read: assert property (rdAt(8'h06) |=> regRdata == {$past(remoteDesAddr), 1'b0})
		else $error("des read wrong");
	chk_addr_frozen: assert property (learnedValid && addressFreeze && !regWrite |=> $stable(remoteDesAddr))
		else $error("frozen addr moved");
	chk_zero_addr: assert property (i2cAddrValid && i2cAddr == 7'h00 |=> !fwdValid)
		else $error("zero addr forwarded");
	chk_des_fwd: assert property (i2cAddrValid && i2cAddr == remoteDesAddr && remoteDesAddr != 7'h00 |=> fwdValid)
		else $error("des hit dropped");
	chk_fwd_cause: assert property (fwdValid |-> $past(i2cAddrValid))
		else $error("forward without request");
	chk_clr_held: assert property (clrHeld |=> regRdata == 8'h00)
		else $error("count not cleared");
	chk_unmapped_zero: assert property (rdAt(8'h09) |=> regRdata == 8'h00)
		else $error("unmapped read nonzero");
endmodule
bind rim_link_status rim_link_status_chk u_chk (
	.clk(clk),
	.rst(rst),
	.regAddr(regAddr),
	.regWrite(regWrite),
	.regRead(regRead),
	.regWdata(regWdata),
	.regRdata(regRdata),
	.counterClear(counterClear),
	.addressFreeze(addressFreeze),
	.learnedValid(learnedValid),
	.i2cAddr(i2cAddr),
	.i2cAddrValid(i2cAddrValid),
	.fwdValid(fwdValid),
	.remoteDesAddr(remoteDesAddr)
);

// ==== rim_link_status_tb.sv ====
`timescale 1ns/1ps
module rim_link_status_tb;
	logic clk = 0, rst = 1, regWrite = 0, regRead = 0, counterClear = 0, addressFreeze = 0, rdSeen = 0;
	logic rxLockPin = 0, linkDetectPin = 0, pclkValidPin = 0, i2cAddrValid = 0, fwdValid, fwdToTarget;
	logic [7:0] regAddr = 0, regWdata = 0, regRdata, expRd[$], expFwd[$];
	logic [6:0] i2cAddr = 0, learnedAddr, fwdAddr, remoteDesAddr, phys, aliasVal, desVal, n;
	logic [4:0] ev;
	int mismatches = 0, checks_done = 0;
	always #10 clk = ~clk;
	rim_far_end i_far (.clk(clk), .learnedAddr(learnedAddr), .ev(ev));
	rim_link_status i_dut (
		.clk(clk),
		.rst(rst),
		.regAddr(regAddr),
		.regWrite(regWrite),
		.regRead(regRead),
		.regWdata(regWdata),
		.regRdata(regRdata),
		.counterClear(counterClear),
		.addressFreeze(addressFreeze),
		.rxLockPin(rxLockPin),
		.linkDetectPin(linkDetectPin),
		.pclkValidPin(pclkValidPin),
		.learnedAddr(learnedAddr),
		.learnedValid(ev[4]),
		.backchannelCrcErr(ev[3]),
		.selftestRestart(ev[2]),
		.selftestCrcErr(ev[1]),
		.desCrcErr(ev[0]),
		.i2cAddr(i2cAddr),
		.i2cAddrValid(i2cAddrValid),
		.fwdValid(fwdValid),
		.fwdAddr(fwdAddr),
		.fwdToTarget(fwdToTarget),
		.remoteDesAddr(remoteDesAddr)
	);
	task automatic cmp(string nm, logic [7:0] e, logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	always @(posedge clk) begin
		if (rdSeen) cmp("regRdata", expRd.pop_front(), regRdata);
		if (fwdValid) cmp("fwd", expFwd.pop_front(), {fwdToTarget, fwdAddr});
		rdSeen <= regRead;
	end
	task rd(input [7:0] a, input [7:0] e);
		@(posedge clk) #1;
		regRead = 1;
		regAddr = a;
		expRd.push_back(e);
		@(posedge clk) #1;
		regRead = 0;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk) #1;
		regWrite = 1;
		regAddr = a;
		regWdata = d;
		@(posedge clk) #1;
		regWrite = 0;
	endtask
	task req(input [6:0] a, input hit, input [7:0] e);
		@(posedge clk) #1;
		i2cAddrValid = 1;
		i2cAddr = a;
		if (hit) expFwd.push_back(e);
		@(posedge clk) #1;
		i2cAddrValid = 0;
	endtask
	task give_verdict;
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#20000;
		$display("[ERR] watchdog expected finish seen timeout");
		mismatches++;
		give_verdict;
	end
	initial begin
		void'($urandom(8652));
		repeat (12) @(posedge clk);
		#1 rst = 0;
		for (int a = 6; a < 13; a++) rd(a[7:0], 8'h00);
		phys = $urandom;
		aliasVal = $urandom % 127 + 1;
		wr(8'h07, {phys, 1'b1});
		wr(8'h08, {aliasVal, 1'b1});
		wr(8'h0a, 8'hff);
		rd(8'h07, {phys, 1'b0});
		rd(8'h08, {aliasVal, 1'b0});
		rd(8'h0a, 8'h00);
		req(aliasVal, 1, {1'b1, phys});
		req(7'h00, 0, 8'h00);
		rxLockPin = 1;
		i_far.send(5'h10, 7'h2c, 6);
		rd(8'h06, 8'h58);
		addressFreeze = 1;
		i_far.send(5'h10, 7'h13, 0);
		rd(8'h06, 8'h58);
		req(7'h2c, 1, aliasVal == 7'h2c ? {1'b1, phys} : 8'h2c);
		desVal = $urandom % 127 + 1;
		wr(8'h06, {desVal, 1'b1});
		rd(8'h06, {desVal, 1'b0});
		i_far.send(5'h10, 7'h2c, 0);
		rd(8'h06, {desVal, 1'b0});
		req(desVal, 1, aliasVal == desVal ? {1'b1, phys} : {1'b0, desVal});
		n = $urandom % 8 + 3;
		repeat (n) i_far.send(5'h08, 7'h00, $urandom % 2);
		rd(8'h0a, {1'b0, n});
		rd(8'h0b, 8'h00);
		counterClear = 1;
		i_far.send(5'h08, 7'h00, 0);
		rd(8'h0a, 8'h00);
		rd(8'h0b, 8'h00);
		counterClear = 0;
		i_far.send(5'h08, 7'h00, 0);
		rd(8'h0a, 8'h01);
		linkDetectPin = 1;
		pclkValidPin = 1;
		i_far.send(5'h03, 7'h00, 6);
		rd(8'h0c, 8'h0f);
		i_far.send(5'h04, 7'h00, 0);
		rd(8'h0c, 8'h07);
		linkDetectPin = 0;
		repeat (7) @(posedge clk);
		rd(8'h0c, 8'h04);
		i_far.send(5'h03, 7'h00, 0);
		counterClear = 1;
		rd(8'h0c, 8'h04);
		counterClear = 0;
		repeat (2) @(posedge clk);
		#1;
		cmp("pending", 8'h00, expRd.size() + expFwd.size());
		give_verdict;
	end
endmodule

// ==== rim_sync3.v ====
`timescale 1ns/1ps
`include "rim_consts.vh"
// ==========================================================
// three-stage synchroniser; output moves only once stages two and three agree
module rim_sync3 #(
	parameter WIDTH = 3
) (
	clk,
	rst,
	asyncIn,
	syncOut
);
	input wire clk;
	input wire rst;
	input wire [WIDTH-1:0] asyncIn;
	output reg [WIDTH-1:0] syncOut;

	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;
	reg [WIDTH-1:0] stage3_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gBit
			always @(posedge clk) begin
				if (rst) begin
					stage1_reg[i] <= 1'b0;
					stage2_reg[i] <= 1'b0;
					stage3_reg[i] <= 1'b0;
					syncOut[i] <= 1'b0;
				end else begin
					stage1_reg[i] <= asyncIn[i];
					stage2_reg[i] <= stage1_reg[i];
					stage3_reg[i] <= stage2_reg[i];
					// a single disagreeing sample is treated as not yet settled
					if (stage2_reg[i] == stage3_reg[i]) begin
						syncOut[i] <= stage3_reg[i];
					end
				end
			end
		end
	endgenerate
endmodule
